// ### common/mpmi_pkg.sv
// constants and carrier types for the media interface block
package mpmi_pkg;
	// system clock
	localparam int CLK_PERIOD_NS = 25;
	// synchroniser vector layout
	localparam int SY_W = 12;
	localparam int SY_REF = 11;
	localparam int SY_RXC = 10;
	localparam int SY_TXC = 9;
	localparam int SY_RXD = 5;
	localparam int SY_RXDV = 4;
	localparam int SY_CRSDV = 3;
	localparam int SY_RXER = 2;
	localparam int SY_CRS = 1;
	localparam int SY_MDIO = 0;
	// management frame layout, bit index counted from the first preamble bit
	localparam int MD_FRAME_BITS = 64;
	localparam int MD_TA_IDX = 46;
	localparam int MD_DATA_IDX = 48;
	localparam int MD_LAST_IDX = 63;
	localparam logic [31:0] MD_PREAMBLE = 32'hFFFFFFFF;
	localparam logic [1:0] MD_START = 2'h1;
	localparam logic [1:0] MD_OP_READ = 2'h2;
	localparam logic [1:0] MD_OP_WRITE = 2'h1;
	localparam logic [1:0] MD_TA_WRITE = 2'h2;
	// reset value and minimum MDC half period
	localparam logic [3:0] NIBBLE_RST = 4'h0;
	localparam logic [7:0] MDC_HALF_MIN = 8'h01;

	// one received nibble or dibit with its qualifiers
	typedef struct packed {
		logic [3:0] data;
		logic valid;
		logic error;
	} mpmi_rx_s;

	// one management request
	typedef struct packed {
		logic read;
		logic [4:0] phy_addr;
		logic [4:0] reg_addr;
		logic [15:0] wdata;
	} mpmi_mgmt_s;
endpackage

// ### logic/mpmi_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module mpmi_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	generate
		if (W < 1)
		begin : g_bad_width
			$error("mpmi_sync: W must be at least 1");
		end
	endgenerate

	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// first stage feeds the second stage only
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			q_reg <= '0;
		end
		else
		begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule

// ### logic/mpmi_top.sv
// PHY-facing MII/RMII pin logic with collision, carrier and management port
`timescale 1ns/1ps
module mpmi_top
	import mpmi_pkg::*;
#(
	parameter int HALF_W = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// mode selection, high for reduced interface, taken during reset
	input wire logic reduced_mode_sel,
	// PHY clock pins
	input wire logic mii_receive_clock,
	input wire logic mii_transmit_clock,
	input wire logic rmii_reference_clock,
	// PHY receive pins
	input wire logic [3:0] receive_nibble,
	input wire logic receive_valid,
	input wire logic carrier_data_valid,
	input wire logic receive_error,
	// PHY status pins
	input wire logic collision,
	input wire logic carrier_sense,
	// PHY transmit pins
	output logic [3:0] transmit_nibble,
	output logic [1:0] transmit_dibit,
	// management pins
	output logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	// user receive side
	output mpmi_rx_s rx_word,
	output logic rx_strobe,
	// user transmit side
	input wire logic [3:0] tx_word,
	output logic tx_take,
	// user status side
	output logic col_tx,
	output logic col_rx,
	output logic crs_tx,
	// user management side
	input wire logic [HALF_W-1:0] mdc_half_period,
	input wire logic mgmt_start,
	input wire mpmi_mgmt_s mgmt_req,
	output logic mgmt_busy,
	output logic mgmt_done,
	output logic [15:0] mgmt_rdata
);
	generate
		if (HALF_W < 1 || HALF_W > 16)
		begin : g_bad_width
			$error("mpmi_top: HALF_W must be 1 to 16");
		end
	endgenerate

	typedef enum logic [1:0] {MD_IDLE, MD_RUN, MD_FINISH} mpmi_md_state_e;

	// a zero half period would stall the divider, so it counts as one
	function automatic logic [HALF_W-1:0] eff_half(input logic [HALF_W-1:0] h);
		eff_half = (h == '0) ? HALF_W'(MDC_HALF_MIN) : h;
	endfunction

	logic [SY_W-1:0] sync_q;
	logic col_tx_s;
	logic col_rx_s;
	logic mode_reg;
	logic rxc_prev_reg;
	logic txc_prev_reg;
	logic rx_rise;
	logic tx_rise;
	mpmi_rx_s rx_word_reg;
	logic rx_strobe_reg;
	logic [3:0] tx_pins_reg;
	logic tx_take_reg;
	logic col_tx_reg;
	logic col_rx_reg;
	logic crs_tx_reg;
	mpmi_md_state_e md_state_reg;
	logic [HALF_W-1:0] div_cnt_reg;
	logic mdc_reg;
	logic div_term;
	logic mdc_rise_en;
	logic mdc_fall_en;
	logic [MD_FRAME_BITS-1:0] frame_reg;
	logic [5:0] bit_idx_reg;
	logic read_reg;
	logic mdio_out_reg;
	logic mdio_oe_n_reg;
	logic [15:0] rdata_reg;
	logic done_reg;

	// pins from the PHY domain; collision gets its own two synchronisers
	mpmi_sync #(.W(SY_W)) u_sync_pins (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({rmii_reference_clock, mii_receive_clock, mii_transmit_clock, receive_nibble,
			receive_valid, carrier_data_valid, receive_error, carrier_sense, mdio_in}),
		.q(sync_q)
	);
	mpmi_sync #(.W(1)) u_sync_col_tx (
		.clk_sys(clk_sys),
		.rst(rst),
		.d(collision),
		.q(col_tx_s)
	);
	mpmi_sync #(.W(1)) u_sync_col_rx (
		.clk_sys(clk_sys),
		.rst(rst),
		.d(collision),
		.q(col_rx_s)
	);

	// mode is loaded from the select pin while in reset and frozen afterwards
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			mode_reg <= reduced_mode_sel;
	end

	// rising edges of the active receive and transmit clocks
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rxc_prev_reg <= 1'b0;
			txc_prev_reg <= 1'b0;
		end
		else
		begin
			rxc_prev_reg <= mode_reg ? sync_q[SY_REF] : sync_q[SY_RXC];
			txc_prev_reg <= mode_reg ? sync_q[SY_REF] : sync_q[SY_TXC];
		end
	end
	assign rx_rise = (mode_reg ? sync_q[SY_REF] : sync_q[SY_RXC]) & ~rxc_prev_reg;
	assign tx_rise = (mode_reg ? sync_q[SY_REF] : sync_q[SY_TXC]) & ~txc_prev_reg;

	// receive capture, data delayed alongside its clock
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rx_word_reg <= '0;
			rx_strobe_reg <= 1'b0;
		end
		else
		begin
			rx_strobe_reg <= rx_rise;
			if (rx_rise && mode_reg)
			begin
				rx_word_reg.data <= {2'h0, sync_q[SY_RXD+1:SY_RXD]};
				rx_word_reg.valid <= sync_q[SY_CRSDV];
				rx_word_reg.error <= sync_q[SY_RXER];
			end
			else if (rx_rise)
			begin
				rx_word_reg.data <= sync_q[SY_RXD+3:SY_RXD];
				rx_word_reg.valid <= sync_q[SY_RXDV];
				rx_word_reg.error <= sync_q[SY_RXER];
			end
		end
	end

	// transmit pins change only at a transmit clock rising edge
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tx_pins_reg <= NIBBLE_RST;
			tx_take_reg <= 1'b0;
		end
		else
		begin
			tx_take_reg <= tx_rise;
			if (tx_rise && mode_reg)
				tx_pins_reg <= {2'h0, tx_word[1:0]};
			else if (tx_rise)
				tx_pins_reg <= tx_word;
		end
	end

	// collision taken into transmit and receive timing, carrier into transmit timing only
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			col_tx_reg <= 1'b0;
			col_rx_reg <= 1'b0;
			crs_tx_reg <= 1'b0;
		end
		else
		begin
			if (tx_rise)
			begin
				col_tx_reg <= col_tx_s;
				crs_tx_reg <= sync_q[SY_CRS];
			end
			if (rx_rise)
				col_rx_reg <= col_rx_s;
		end
	end

	// MDC divider runs only while a frame is in flight
	assign div_term = (md_state_reg != MD_IDLE)
		&& (div_cnt_reg == eff_half(mdc_half_period) - 1'b1);
	assign mdc_rise_en = div_term & ~mdc_reg;
	assign mdc_fall_en = div_term & mdc_reg;
	always_ff @(posedge clk_sys)
	begin
		if (rst || md_state_reg == MD_IDLE)
		begin
			div_cnt_reg <= '0;
			mdc_reg <= 1'b0;
		end
		else if (div_term)
		begin
			div_cnt_reg <= '0;
			mdc_reg <= ~mdc_reg;
		end
		else
			div_cnt_reg <= div_cnt_reg + 1'b1;
	end

	// management frame sequencer on the shared two wires
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			md_state_reg <= MD_IDLE;
			frame_reg <= '0;
			bit_idx_reg <= '0;
			read_reg <= 1'b0;
			mdio_out_reg <= 1'b1;
			mdio_oe_n_reg <= 1'b1;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= 1'b0;
			case (md_state_reg)
				MD_IDLE:
				begin
					mdio_oe_n_reg <= 1'b1;
					if (mgmt_start)
					begin
						frame_reg <= {MD_PREAMBLE, MD_START,
							mgmt_req.read ? MD_OP_READ : MD_OP_WRITE,
							mgmt_req.phy_addr, mgmt_req.reg_addr, MD_TA_WRITE,
							mgmt_req.wdata};
						read_reg <= mgmt_req.read;
						bit_idx_reg <= '0;
						mdio_out_reg <= 1'b1;
						mdio_oe_n_reg <= 1'b0;
						md_state_reg <= MD_RUN;
					end
				end
				MD_RUN:
				begin
					if (mdc_rise_en && bit_idx_reg == 6'(MD_LAST_IDX))
						md_state_reg <= MD_FINISH;
					else if (mdc_fall_en)
					begin
						bit_idx_reg <= bit_idx_reg + 1'b1;
						frame_reg <= {frame_reg[MD_FRAME_BITS-2:0], 1'b0};
						mdio_out_reg <= frame_reg[MD_FRAME_BITS-2];
						if (read_reg && bit_idx_reg + 1'b1 >= 6'(MD_TA_IDX))
							mdio_oe_n_reg <= 1'b1;
					end
				end
				MD_FINISH:
				begin
					if (mdc_fall_en)
					begin
						mdio_oe_n_reg <= 1'b1;
						mdio_out_reg <= 1'b1;
						done_reg <= 1'b1;
						md_state_reg <= MD_IDLE;
					end
				end
				default: md_state_reg <= MD_IDLE;
			endcase
		end
	end

	// read data shifted in at MDC rising edges of the data phase
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rdata_reg <= '0;
		else if (md_state_reg == MD_RUN && mdc_rise_en && read_reg
			&& bit_idx_reg >= 6'(MD_DATA_IDX))
			rdata_reg <= {rdata_reg[14:0], sync_q[SY_MDIO]};
	end

	// outputs
	assign transmit_nibble = tx_pins_reg;
	assign transmit_dibit = tx_pins_reg[1:0];
	assign rx_word = rx_word_reg;
	assign rx_strobe = rx_strobe_reg;
	assign tx_take = tx_take_reg;
	assign col_tx = col_tx_reg;
	assign col_rx = col_rx_reg;
	assign crs_tx = crs_tx_reg;
	assign mdc = mdc_reg;
	assign mdio_out = mdio_out_reg;
	assign mdio_oe_n = mdio_oe_n_reg;
	assign mgmt_busy = (md_state_reg != MD_IDLE);
	assign mgmt_done = done_reg;
	assign mgmt_rdata = rdata_reg;

	// checks
	a_rx_mii_capture: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_rise && !mode_reg) |=> (rx_strobe && rx_word.data == $past(sync_q[SY_RXD+3:SY_RXD])
		&& rx_word.valid == $past(sync_q[SY_RXDV])))
		else $error("mii receive capture wrong");
	a_rx_rmii_capture: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_rise && mode_reg) |=> (rx_word.data[1:0] == $past(sync_q[SY_RXD+1:SY_RXD])
		&& rx_word.valid == $past(sync_q[SY_CRSDV]) && rx_word.data[3:2] == 2'h0))
		else $error("rmii receive capture wrong");
	a_tx_mii_update: assert property (@(posedge clk_sys) disable iff (rst)
		($changed(transmit_nibble) && !mode_reg) |-> $past(tx_rise))
		else $error("mii transmit changed off edge");
	a_tx_rmii_update: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_rise && mode_reg) |=> (transmit_dibit == $past(tx_word[1:0]) && tx_take))
		else $error("rmii transmit not loaded");
	a_col_two_paths: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_rise && !tx_rise) |=> (col_rx == $past(col_rx_s) && col_tx == $past(col_tx)))
		else $error("collision path mixed up");
	a_crs_tx_only: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(crs_tx) |-> $past(tx_rise))
		else $error("carrier changed off transmit edge");
	a_mdio_fall_only: assert property (@(posedge clk_sys) disable iff (rst)
		($changed(mdio_out) && !$past(md_state_reg == MD_IDLE)) |-> $past(mdc_fall_en))
		else $error("mdio changed off mdc fall");
	a_mdc_half_period: assert property (@(posedge clk_sys) disable iff (rst)
		($changed(mdc) && mdc) |-> $past(div_cnt_reg) == eff_half(mdc_half_period) - 1'b1)
		else $error("mdc half period wrong");
	a_read_sample: assert property (@(posedge clk_sys) disable iff (rst)
		(md_state_reg == MD_RUN && mdc_rise_en && read_reg && bit_idx_reg >= 6'(MD_DATA_IDX))
		|=> rdata_reg[0] == $past(sync_q[SY_MDIO]))
		else $error("mdio read not sampled");
	a_read_release: assert property (@(posedge clk_sys) disable iff (rst)
		(read_reg && md_state_reg != MD_IDLE && bit_idx_reg >= 6'(MD_TA_IDX)) |-> mdio_oe_n)
		else $error("line driven during read turnaround");
	a_mode_frozen: assert property (@(posedge clk_sys) disable iff (rst)
		!$rose(mode_reg) && !$fell(mode_reg))
		else $error("mode changed after reset");
endmodule

// ### verif/mpmi_phy_model.sv
// behavioural PHY: pin clocks, receive pins and management responder
`timescale 1ns/1ps
module mpmi_phy_model (
	// bench control
	input wire logic rst,
	input wire logic rmii,
	input wire logic [5:0] rx_src,
	input wire logic [15:0] rd_src,
	// PHY clock and receive pins
	output logic rx_clk,
	output logic tx_clk,
	output logic ref_clk,
	output logic [3:0] rx_d,
	output logic rx_dv,
	output logic crs_dv,
	output logic rx_er,
	// management wire
	input wire logic mdc,
	input wire logic line,
	output logic phy_oe,
	output logic phy_d,
	output logic [63:0] sh
);
	int cnt;
	logic rd;
	wire rclk = rmii ? ref_clk : rx_clk;
	// free clocks, phase unrelated to the system clock
	initial
	begin
		rx_clk = 1'h0;
		tx_clk = 1'h0;
		ref_clk = 1'h0;
		phy_oe = 1'h0;
		fork
			#7 forever #100 rx_clk = !rx_clk;
			#3 forever #130 tx_clk = !tx_clk;
			#11 forever #80 ref_clk = !ref_clk;
		join
	end
	// pins move at the falling edge, steady across the rising one
	always @(negedge rclk)
	begin
		rx_d <= rx_src[3:0];
		rx_dv <= !rmii && rx_src[4];
		crs_dv <= rmii && rx_src[4];
		rx_er <= rx_src[5];
	end
	// shift the line in at each clock rise, spot a read opcode
	always @(posedge mdc or posedge rst)
	begin
		if (rst)
		begin
			cnt = 0;
			rd = 1'h0;
		end
		else
		begin
			sh = {sh[62:0], line};
			cnt++;
			if (cnt == 36)
				rd = sh[1:0] == 2'h2;
			if (cnt == 64)
				cnt = 0;
		end
	end
	// turnaround zero and read data after the fall, else released
	always @(negedge mdc or posedge rst)
	begin
		phy_oe <= !rst && rd && cnt >= 47;
		phy_d <= cnt >= 48 && rd_src[63 - cnt];
	end
endmodule

// ### verif/mpmi_top_bench.sv
// random bench for the media interface block in both modes
`timescale 1ns/1ps
module mpmi_top_bench;
	import mpmi_pkg::*;
	logic clk_sys = 1'h0, rst = 1'h1, mode = 1'h0, col = 1'h0, crs = 1'h0, mstart = 1'h0;
	logic [3:0] tx_word = 4'h0;
	logic [5:0] rx_src = 6'h00;
	logic [15:0] rd_src = 16'h0000;
	logic [7:0] half = 8'h04;
	logic [31:0] rnd = 32'hBDB07FD9;
	mpmi_mgmt_s req = '0;
	int err_total = 0, n_checks = 0, arm = 0, nrx = 0, ntx = 0;
	logic [5:0] q[$];
	wire rxc, txc, refc, rxdv, crsdv, rxer, mdc, mo, moe_n, poe, pd;
	wire rstb, take, ctx, crx, cstx, busy, done;
	wire [3:0] rxd, txn;
	wire [1:0] txd;
	wire [15:0] rdata;
	wire [63:0] sh;
	wire mpmi_rx_s rw;
	// released line floats high through the pull-up
	wire line = !moe_n ? mo : (poe ? pd : 1'h1);

	mpmi_top #(.HALF_W(8)) mpmi_top_i (.clk_sys(clk_sys), .rst(rst), .reduced_mode_sel(mode),
		.mii_receive_clock(rxc), .mii_transmit_clock(txc), .rmii_reference_clock(refc),
		.receive_nibble(rxd), .receive_valid(rxdv), .carrier_data_valid(crsdv),
		.receive_error(rxer), .collision(col), .carrier_sense(crs), .transmit_nibble(txn),
		.transmit_dibit(txd), .mdc(mdc), .mdio_in(line), .mdio_out(mo), .mdio_oe_n(moe_n),
		.rx_word(rw), .rx_strobe(rstb), .tx_word(tx_word), .tx_take(take), .col_tx(ctx),
		.col_rx(crx), .crs_tx(cstx), .mdc_half_period(half), .mgmt_start(mstart),
		.mgmt_req(req), .mgmt_busy(busy), .mgmt_done(done), .mgmt_rdata(rdata));
	mpmi_phy_model mpmi_phy_model_i (.rst(rst), .rmii(mode), .rx_src(rx_src), .rd_src(rd_src),
		.rx_clk(rxc), .tx_clk(txc), .ref_clk(refc), .rx_d(rxd), .rx_dv(rxdv), .crs_dv(crsdv),
		.rx_er(rxer), .mdc(mdc), .line(line), .phy_oe(poe), .phy_d(pd), .sh(sh));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// word as the pins showed it; reduced mode keeps two bits
	function automatic mpmi_rx_s exp_rx(input logic m, input logic [5:0] p);
		return '{m ? {2'h0, p[1:0]} : p[3:0], p[4], p[5]};
	endfunction
	// whole management frame as it should cross the line
	function automatic logic [63:0] exp_frame(input mpmi_mgmt_s r, input logic [15:0] d);
		return {MD_PREAMBLE, MD_START, r.read ? MD_OP_READ : MD_OP_WRITE, r.phy_addr,
			r.reg_addr, MD_TA_WRITE, r.read ? d : r.wdata};
	endfunction
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// record the pins at each receive rising edge
	always @(posedge (mode ? refc : rxc))
		if (arm > 5)
			q.push_back({rxer, mode ? crsdv : rxdv, rxd});
	// random stream, receive and transmit checks
	always @(posedge clk_sys)
	begin
		rnd <= lfsr(rnd);
		rx_src <= rnd[5:0];
		arm <= rst ? 0 : (arm < 12 ? arm + 1 : arm);
		if (rstb === 1'h1)
		begin
			nrx <= nrx + 1;
			if (q.size() > 0)
				chk("rx_word", exp_rx(mode, q.pop_front()), rw);
			else if (arm == 12)
				chk("rx_extra", 0, 1);
		end
		if (take === 1'h1)
		begin
			ntx <= ntx + 1;
			chk("tx_pins", mode ? tx_word[1:0] : tx_word, mode ? txd : txn);
			tx_word <= rnd[9:6];
		end
		// flush after the checks, so a strobe launched just before reset still pops its word
		if (rst)
		begin
			q.delete();
			nrx <= 0;
			ntx <= 0;
		end
	end

	// one frame, with a second start thrown in while busy
	task automatic mgmt(input logic rd, input logic [7:0] h);
		int n;
		logic [15:0] d;
		mpmi_mgmt_s r;
		r = {rd, rnd[9:0], rnd[31:16]};
		d = rnd[25:10];
		half <= h;
		rd_src <= d;
		@(posedge clk_sys);
		req <= r;
		mstart <= 1'h1;
		@(posedge clk_sys);
		mstart <= 1'h0;
		repeat (40) @(posedge clk_sys);
		chk("mgmt_busy", 1, busy);
		req <= ~r;
		mstart <= 1'h1;
		@(posedge clk_sys);
		mstart <= 1'h0;
		n = 41;
		while (done !== 1'h1 && n < 3000)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk("mgmt_idle", 0, busy);
		// done follows the last falling edge: 64 full MDC periods after the start edge
		chk("mgmt_time", 1, n >= 2 * MD_FRAME_BITS * h + 1 && n <= 2 * MD_FRAME_BITS * h + 3);
		chk("frame", exp_frame(r, d), sh);
		if (rd)
			chk("rdata", d, rdata);
	endtask
	// reset into one mode, then status and management traffic
	task automatic run_mode(input logic m);
		// mode moves one edge into reset, after the last strobe of the old mode is checked
		rst <= 1'h1;
		@(posedge clk_sys);
		mode <= m;
		repeat (7) @(posedge clk_sys);
		rst <= 1'h0;
		for (int i = 0; i < 10; i++)
		begin
			col <= rnd[10];
			crs <= rnd[11];
			repeat (40) @(posedge clk_sys);
			chk("col_tx", col, ctx);
			chk("col_rx", col, crx);
			chk("crs_tx", crs, cstx);
		end
		mgmt(1'h0, 8'h04);
		mgmt(1'h1, 8'h05);
		chk("rx_seen", 1, nrx > 20);
		chk("tx_seen", 1, ntx > 10);
	endtask

	initial
		forever #12.5 clk_sys = !clk_sys;
	// watchdog far past the expected run length
	initial
	begin
		#(25 * 20000);
		err_total++;
		close_out();
	end
	initial
	begin
		run_mode(1'h0);
		run_mode(1'h1);
		close_out();
	end
endmodule
